// ===== core/xmhk_defines.svh
// constants for the external memory high-mask and bus-keeper block
// assumes inclusion by bare name from the package; the modules use its macros without including it
`ifndef XMHK_DEFINES_SVH
`define XMHK_DEFINES_SVH

// register byte offsets on the register bus
`define XMHK_OFF_CTRL_B 8'h00
`define XMHK_OFF_CTRL 8'h04
`define XMHK_OFF_PORT_OUT 8'h08
`define XMHK_OFF_PORT_DIR 8'h0C
`define XMHK_OFF_STATUS 8'h10

// field positions
`define XMHK_KEEP_BIT 7
`define XMHK_ENABLE_BIT 7
`define XMHK_MASK_HI 2
`define XMHK_BUSY_BIT 0
`define XMHK_INT_BIT 1

// reset values
`define XMHK_RST_BYTE 8'h00
`define XMHK_RST_MASK 3'h0

// mask code that releases the whole high port
`define XMHK_MASK_ALL 3'h7
`define XMHK_PINS 8

// last address that belongs to internal memory
`define XMHK_INT_TOP 16'h10FF

// strobe length in clock cycles, covers the input synchroniser
`define XMHK_STROBE_CYC 2'h3

// bus responses
`define XMHK_RESP_OKAY 2'h0
`define XMHK_RESP_DECERR 2'h3

`endif

// ===== core/xmhk_pkg.sv
// types shared by the external memory high-mask block
// assumes the defines header sits beside it
package xmhk_pkg;
  `include "xmhk_defines.svh"

  typedef logic [15:0] xmhk_addr_t; // external bus address
  typedef logic [7:0] xmhk_byte_t; // one data byte

  // access sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ADDR = 4'h2,
    ST_STRB = 4'h4,
    ST_END = 4'h8
  } xmhk_state_e_t;

  // whole state of the top module
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [7:0] wbyte;
    logic wlane;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic keep_en;
    logic [2:0] mask;
    logic mem_en;
    logic [7:0] port_out;
    logic [7:0] port_dir;
    xmhk_state_e_t st;
    logic [1:0] cnt;
    logic [15:0] a;
    logic [2:0] acc_mask;
    logic we;
    logic [7:0] wd;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] kept;
    logic [7:0] ad_o;
    logic [7:0] ad_oe_n;
    logic [7:0] hp_o;
    logic [7:0] hp_oe_n;
    logic ale;
    logic wr_n;
    logic rd_n;
    logic ctl_oe_n;
    logic keep_drive;
    logic acc_ready;
    logic acc_done;
    logic acc_internal;
    logic [7:0] acc_rdata;
  } xmhk_st_t;
endpackage

// ===== core/xmhk_pin_mux.sv
// per-pin choice between high address and ordinary port function
// assumes the caller registers every output
`timescale 1ns/10ps
module xmhk_pin_mux
  import xmhk_pkg::*;
#(
  parameter int PINS = `XMHK_PINS
) (
  input wire logic mem_en,
  input wire logic [2:0] mask,
  input wire logic drive_addr,
  input wire logic [PINS-1:0] addr_hi,
  input wire logic [PINS-1:0] port_out,
  input wire logic [PINS-1:0] port_dir,
  output logic [PINS-1:0] pin_o,
  output logic [PINS-1:0] pin_oe_n
);
  // pins released counted from the top; all-ones code frees every pin
  logic [3:0] released;
  assign released = (mask == `XMHK_MASK_ALL) ? 4'(PINS) : {1'b0, mask}; // R08

  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      logic freed; // pin handed back to the port
      assign freed = !mem_en || (4'(i) >= 4'(PINS) - released);
      // interface pins ignore the direction setting while enabled
      assign pin_o[i] = freed ? port_out[i] : addr_hi[i]; // R09
      // address is only driven in the address phase and strobe
      assign pin_oe_n[i] = freed ? !port_dir[i] : !drive_addr; // R12
    end
  endgenerate
endmodule

// ===== core/xmhk_top.sv
// external memory high-mask and bus-keeper control with its pin logic
// assumes an AXI4-Lite master on clk and pads resolved outside
//
// Functional notes
// R01 - keeper bit one enables data-line keepers
// R02 - keeper holds last driven value when released
// R03 - keeper bit zero disables the keepers
// R04 - keeper works even with interface disabled
// R05 - bits six to four always read zero
// R06 - software writes zeros into reserved bits
// R07 - mask zero: all eight high pins address
// R08 - mask code sets pins released from top
// R09 - released pins follow port output, direction
// R10 - addresses up to 0x10FF stay internal
// R11 - software masks pins to reach low memory
// R12 - enable overrides direction for interface pins
// R13 - mask change applies from next access
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module xmhk_top
  import xmhk_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // access requests from the core
  input wire logic acc_req,
  input wire xmhk_pkg::xmhk_addr_t acc_addr,
  input wire logic acc_we,
  input wire xmhk_pkg::xmhk_byte_t acc_wdata,
  output logic acc_ready,
  output logic acc_done,
  output logic acc_internal,
  output xmhk_pkg::xmhk_byte_t acc_rdata,
  // multiplexed address/data pins
  input wire logic [7:0] muxed_addr_data_i,
  output logic [7:0] muxed_addr_data_o,
  output logic [7:0] muxed_addr_data_oe_n,
  output logic [7:0] keeper_value,
  output logic keeper_drive,
  // high address port pins
  output logic [7:0] high_port_o,
  output logic [7:0] high_port_oe_n,
  // strobes
  output logic ale,
  output logic wr_n,
  output logic rd_n,
  output logic strobe_oe_n
);
  import xmhk_pkg::*;

  xmhk_st_t s; // registered state
  xmhk_st_t n; // next state
  logic [7:0] next_hp_o; // pin mux result
  logic [7:0] next_hp_oe_n;
  logic drive_addr; // address shown on high pins in next cycle
  logic take; // access request taken this edge
  logic is_int; // request targets internal memory

  assign take = acc_req && s.acc_ready;
  assign is_int = acc_addr <= `XMHK_INT_TOP;

  // high pins: mask latched per access, live mask while idle
  xmhk_pin_mux xmhk_pin_mux_i (
    .mem_en(n.mem_en),
    .mask(n.st == ST_IDLE ? n.mask : n.acc_mask),
    .drive_addr(drive_addr),
    .addr_hi(n.a[15:8]),
    .port_out(n.port_out),
    .port_dir(n.port_dir),
    .pin_o(next_hp_o),
    .pin_oe_n(next_hp_oe_n)
  );

  // next-state logic for bus slave, sequencer and pins
  always_comb begin
    n = s;
    drive_addr = 1'b0;
    // write channel: address and data taken in either order
    if (s.awready && s_axi_awvalid) begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      n.w_got = 1'b1;
      n.wbyte = s_axi_wdata[7:0];
      n.wlane = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    // both halves present: commit and answer
    if (s.aw_got && s.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `XMHK_RESP_OKAY;
      case (s.aw_addr)
        `XMHK_OFF_CTRL_B: begin
          if (s.wlane) begin
            n.keep_en = s.wbyte[`XMHK_KEEP_BIT]; // R01 R03
            n.mask = s.wbyte[`XMHK_MASK_HI:0]; // R08
          end
        end
        `XMHK_OFF_CTRL: begin
          if (s.wlane) begin
            n.mem_en = s.wbyte[`XMHK_ENABLE_BIT]; // R12
          end
        end
        `XMHK_OFF_PORT_OUT: begin
          if (s.wlane) begin
            n.port_out = s.wbyte;
          end
        end
        `XMHK_OFF_PORT_DIR: begin
          if (s.wlane) begin
            n.port_dir = s.wbyte;
          end
        end
        `XMHK_OFF_STATUS: begin
          n.bresp = `XMHK_RESP_OKAY; // read-only, writes dropped
        end
        default: begin
          n.bresp = `XMHK_RESP_DECERR;
        end
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // read channel: one answer in flight
    if (s.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s.arready && s_axi_arvalid) begin
      n.rvalid = 1'b1;
      n.rresp = `XMHK_RESP_OKAY;
      n.rdata = '0;
      case (s_axi_araddr)
        `XMHK_OFF_CTRL_B: begin
          // reserved bits stay zero from the clear above
          n.rdata[`XMHK_KEEP_BIT] = s.keep_en; // R05
          n.rdata[`XMHK_MASK_HI:0] = s.mask;
        end
        `XMHK_OFF_CTRL: begin
          n.rdata[`XMHK_ENABLE_BIT] = s.mem_en;
        end
        `XMHK_OFF_PORT_OUT: begin
          n.rdata[7:0] = s.port_out;
        end
        `XMHK_OFF_PORT_DIR: begin
          n.rdata[7:0] = s.port_dir;
        end
        `XMHK_OFF_STATUS: begin
          n.rdata[`XMHK_BUSY_BIT] = (s.st != ST_IDLE);
          n.rdata[`XMHK_INT_BIT] = s.acc_internal;
          n.rdata[15:8] = s.kept;
        end
        default: begin
          n.rresp = `XMHK_RESP_DECERR;
        end
      endcase
    end
    n.arready = !n.rvalid;
    // data-line synchroniser, first stage feeds only the second
    n.sync1 = muxed_addr_data_i;
    n.sync2 = s.sync1;
    // access sequencer
    n.acc_done = 1'b0;
    case (s.st)
      ST_IDLE: begin
        if (take && is_int) begin
          // internal space never reaches the pins
          n.acc_done = 1'b1; // R10
          n.acc_internal = 1'b1;
        end else if (take) begin
          n.st = ST_ADDR;
          n.a = acc_addr;
          n.we = acc_we;
          n.wd = acc_wdata;
          n.acc_mask = s.mask; // R13
          n.acc_internal = 1'b0;
        end
      end
      ST_ADDR: begin
        n.st = ST_STRB;
        n.cnt = `XMHK_STROBE_CYC;
      end
      ST_STRB: begin
        n.cnt = s.cnt - 2'h1;
        if (s.cnt == 2'h1) begin
          n.st = ST_END;
        end
      end
      ST_END: begin
        n.st = ST_IDLE;
        n.acc_done = 1'b1;
        if (!s.we) begin
          n.acc_rdata = s.sync2;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    // a disabled interface takes no requests
    n.acc_ready = (n.st == ST_IDLE) && n.mem_en && !n.acc_done;
    // pins for the next cycle
    drive_addr = (n.st == ST_ADDR) || (n.st == ST_STRB);
    n.ale = (n.st == ST_ADDR);
    n.wr_n = !((n.st == ST_STRB) && n.we);
    n.rd_n = !((n.st == ST_STRB) && !n.we);
    n.ctl_oe_n = !n.mem_en; // R12
    n.ad_oe_n = 8'hFF;
    n.ad_o = s.ad_o;
    if (n.mem_en && n.st == ST_ADDR) begin
      n.ad_o = n.a[7:0];
      n.ad_oe_n = 8'h00;
    end else if (n.mem_en && n.st == ST_STRB && n.we) begin
      n.ad_o = n.wd;
      n.ad_oe_n = 8'h00;
    end
    n.hp_o = next_hp_o; // R07 R09
    n.hp_oe_n = next_hp_oe_n;
    // keeper tracks the last value seen on the lines
    if (n.ad_oe_n == 8'h00) begin
      n.kept = n.ad_o;
    end else if (s.st == ST_END && !s.we) begin
      n.kept = s.sync2;
    end
    // keeper acts on released lines, independent of enable
    n.keep_drive = n.keep_en && (n.ad_oe_n == 8'hFF); // R02 R04
  end

  // single state register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.st <= ST_IDLE;
      s.mask <= `XMHK_RST_MASK;
      s.port_out <= `XMHK_RST_BYTE;
      s.port_dir <= `XMHK_RST_BYTE;
      s.ad_oe_n <= 8'hFF;
      s.hp_oe_n <= 8'hFF;
      s.wr_n <= 1'b1;
      s.rd_n <= 1'b1;
      s.ctl_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rdata = s.rdata;
  assign acc_ready = s.acc_ready;
  assign acc_done = s.acc_done;
  assign acc_internal = s.acc_internal;
  assign acc_rdata = s.acc_rdata;
  assign muxed_addr_data_o = s.ad_o;
  assign muxed_addr_data_oe_n = s.ad_oe_n;
  assign keeper_value = s.kept;
  assign keeper_drive = s.keep_drive;
  assign high_port_o = s.hp_o;
  assign high_port_oe_n = s.hp_oe_n;
  assign ale = s.ale;
  assign wr_n = s.wr_n;
  assign rd_n = s.rd_n;
  assign strobe_oe_n = s.ctl_oe_n;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_reserved_read: assert property ( // R05
    s.arready && s_axi_arvalid && s_axi_araddr == `XMHK_OFF_CTRL_B
    |=> s.rdata[6:3] == 4'h0 && s.rdata[7] == $past(s.keep_en))
    else $error("reserved bits read nonzero");
  chk_keeper_hold: assert property ( // R01 R02
    s.keep_en && s.ad_oe_n == 8'hFF |-> s.keep_drive)
    else $error("keeper idle on released lines");
  chk_keeper_off: assert property ( // R03
    !s.keep_en |-> !s.keep_drive)
    else $error("keeper drives while disabled");
  chk_keeper_indep: assert property ( // R04
    s.keep_en && !s.mem_en |-> s.keep_drive && s.ad_oe_n == 8'hFF)
    else $error("keeper lost with interface off");
  chk_full_addr: assert property ( // R07
    s.st == ST_ADDR && s.acc_mask == 3'h0 && s.mem_en
    |-> s.hp_oe_n == 8'h00 && s.hp_o == s.a[15:8] && s.ale)
    else $error("high byte not on all pins");
  chk_all_released: assert property ( // R08 R09
    s.st == ST_ADDR && s.acc_mask == `XMHK_MASK_ALL
    |-> s.hp_oe_n == ~s.port_dir && s.hp_o == s.port_out)
    else $error("released pins not port driven");
  chk_internal_map: assert property ( // R10
    take && is_int |=> s.acc_done && s.acc_internal && s.ale == 1'b0)
    else $error("internal address reached pins");
  chk_mask_stable: assert property ( // R13
    s.st != ST_IDLE && $past(s.st) != ST_IDLE |-> $stable(s.acc_mask))
    else $error("mask changed mid access");
  chk_strobe_len: assert property ( // read strobe length, XMHK_STROBE_CYC cycles
    $fell(s.rd_n) |-> !s.rd_n [*3] ##1 s.rd_n ##1 s.acc_done)
    else $error("read strobe length wrong");

  cov_write_access: cover property (take && acc_we && !is_int);
  cov_read_access: cover property ($rose(s.acc_done) && !s.we);
  cov_internal: cover property (take && is_int);
  cov_masked: cover property (s.st == ST_ADDR && s.acc_mask == 3'h3);
endmodule

// ===== test/xmhk_mem_model.sv
// behavioural external sram on the multiplexed address/data bus
// assumes registered strobes and resolves the board pads itself
`timescale 1ns/10ps
module xmhk_mem_model (
  input wire logic ale,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] ad_o,
  input wire logic [7:0] ad_oe_n,
  input wire logic [7:0] keep_v,
  input wire logic keep_d,
  input wire logic [7:0] hp_o,
  input wire logic [7:0] hp_oe_n,
  output logic [7:0] pad
);
  logic [7:0] mem [0:65535]; // whole external space
  logic [15:0] lat; // address held by the latch
  logic [7:0] hp; // high pins as the board sees them
  // an undriven high pin shows the inverse, never a stale copy
  assign hp = (hp_o & ~hp_oe_n) | (~hp_o & hp_oe_n);
  // pad level: interface, then memory, then keeper, else floating
  always_comb begin
    if (ad_oe_n == 8'h00) pad = ad_o;
    else if (!rd_n) pad = mem[lat];
    else if (keep_d) pad = keep_v;
    else pad = ~ad_o; // floating lines never echo the last byte
  end
  // address taken just after ale rises, once the pins have settled;
  // a level latch would race the data byte that follows ale's fall
  always @(posedge ale) begin
    #1;
    lat = {hp, ad_o};
  end
  // level write while the write strobe is low
  always @* begin
    if (!wr_n) mem[lat] = ad_o;
  end
endmodule

// ===== test/tb.sv
// self-checking bench for the high-mask and bus-keeper block
// assumes the design files and the sram model are compiled first
`timescale 1ns/10ps
module tb;
  import xmhk_pkg::*;
  logic clk = 0, rst = 1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 0, wvalid = 0, arvalid = 0, acc_req = 0, acc_we = 0;
  logic awready, wready, bvalid, arready, rvalid, acc_ready, acc_done;
  logic [1:0] bresp, rresp, r;
  logic [15:0] acc_addr = 16'h0;
  logic [7:0] acc_wdata = 8'h00, acc_rdata, pad, ad_o, ad_oe_n, kv;
  logic [7:0] hp_o, hp_oe_n, q, rel;
  logic acc_int, kd, ale, wr_n, rd_n, s_oe_n;
  logic [31:0] d;
  int failures = 0, n_compared = 0;
  // bready, rready and the byte strobe are held; wstrb lane 0 only
  xmhk_top xmhk_top_i (.clk(clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .acc_req(acc_req), .acc_addr(acc_addr),
    .acc_we(acc_we), .acc_wdata(acc_wdata), .acc_ready(acc_ready),
    .acc_done(acc_done), .acc_internal(acc_int), .acc_rdata(acc_rdata),
    .muxed_addr_data_i(pad), .muxed_addr_data_o(ad_o),
    .muxed_addr_data_oe_n(ad_oe_n), .keeper_value(kv),
    .keeper_drive(kd), .high_port_o(hp_o), .high_port_oe_n(hp_oe_n),
    .ale(ale), .wr_n(wr_n), .rd_n(rd_n), .strobe_oe_n(s_oe_n));
  xmhk_mem_model xmhk_mem_model_i (.ale(ale), .wr_n(wr_n), .rd_n(rd_n),
    .ad_o(ad_o), .ad_oe_n(ad_oe_n), .keep_v(kv), .keep_d(kd),
    .hp_o(hp_o), .hp_oe_n(hp_oe_n), .pad(pad));
  // free-running clock, 5 ns period
  initial begin
    forever #2.5 clk = ~clk;
  end
  // one comparison, counted either way
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // write: address and data together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    r = bresp;
  endtask
  // read: response taken at the edge rvalid is seen
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask
  // one core access, held until taken, result at the done pulse
  task automatic acc(input logic [15:0] a, input logic w,
    input logic [7:0] v);
    acc_addr <= a;
    acc_we <= w;
    acc_wdata <= v;
    acc_req <= 1;
    do @(posedge clk); while (!acc_ready);
    acc_req <= 0;
    do @(posedge clk); while (!acc_done);
    q = acc_rdata;
  endtask
  // reset value, reserved bits, unmapped place
  task automatic t_regs;
    rd(8'h00);
    check(d, 32'h0);
    wr(8'h00, 8'hFF);
    check({30'h0, r}, 32'h0);
    rd(8'h00);
    check(d, 32'h87);
    // status is read-only: write answered but dropped
    wr(8'h10, 8'hFF);
    check({30'h0, r}, 32'h0);
    // unmapped place answers a decode error
    wr(8'h20, 8'hFF);
    check({30'h0, r}, 32'h3);
    wr(8'h00, 8'h00);
    rd(8'h20);
    check({30'h0, r}, 32'h3);
    check(d, 32'h0);
  endtask
  // keeper with the interface still disabled
  task automatic t_keep;
    wr(8'h00, 8'h80);
    repeat (2) @(posedge clk);
    check({31'h0, kd}, 32'h1);
    check({24'h0, pad}, {24'h0, kv});
    wr(8'h00, 8'h00);
    repeat (2) @(posedge clk);
    check({31'h0, kd}, 32'h0);
  endtask
  // every mask code against released pins and port settings
  task automatic t_mask;
    wr(8'h08, 8'h5A);
    wr(8'h0C, 8'h0F);
    repeat (2) @(posedge clk);
    check({24'h0, hp_oe_n}, 32'hF0);
    check({30'h0, s_oe_n, acc_ready}, 32'h2);
    wr(8'h04, 8'h80);
    for (int m = 0; m < 8; m++) begin
      wr(8'h00, m[7:0]);
      repeat (2) @(posedge clk);
      rel = ~(8'hFF >> ((m == 7) ? 8 : m));
      // idle: released pins follow direction, address pins float
      check({24'h0, hp_oe_n}, {24'h0, ~(rel & 8'h0F)});
      check({24'h0, hp_o & rel}, {24'h0, 8'h5A & rel});
      check({31'h0, s_oe_n}, 32'h0);
    end
  endtask
  // low external locations through masked pins, then full address
  task automatic t_ext;
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'hFF);
    wr(8'h00, 8'h83);
    acc(16'h2001, 1, 8'hAA);
    check({24'h0, xmhk_mem_model_i.mem[16'h0001]}, 32'hAA);
    check({23'h0, kd, kv}, 32'h1AA);
    wr(8'h00, 8'h80);
    acc(16'h2001, 1, 8'h55);
    check({24'h0, xmhk_mem_model_i.mem[16'h2001]}, 32'h55);
    wr(8'h00, 8'h83);
    acc(16'h2001, 0, 8'h00);
    check({24'h0, q}, 32'hAA);
    acc(16'h10FF, 1, 8'h33);
    check({31'h0, acc_int}, 32'h1);
    // status: keeper still holds the byte read back, internal flag set
    rd(8'h10);
    check(d, 32'h0000AA02);
    acc(16'h1100, 1, 8'h77);
    check({31'h0, acc_int}, 32'h0);
    rd(8'h10);
    check(d, 32'h00007700);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    t_regs;
    t_keep;
    t_mask;
    t_ext;
    stop_test;
  end
  // watchdog well beyond the hundred-odd cycles the run needs
  initial begin
    #200000;
    failures++;
    stop_test;
  end
endmodule
